// file: inc/phy_regs_defs.vh
// Offsets, field positions, reset values and timing counts of the PHY
// register bank. Included by the bank module; definitions only.
`ifndef PHY_REGS_DEFS_VH
`define PHY_REGS_DEFS_VH

`define ADDR_NODE_IDENTITY_STATUS 4'h0
`define ADDR_RESET_GAP_CONTROL 4'h1
`define ADDR_CAPABILITY_PORT_COUNT 4'h2
`define ADDR_SPEED_LATENCY_INFO 4'h3
`define ADDR_LINK_POWER_CONFIG 4'h4
`define ADDR_INTERRUPT_ENABLE_STATUS 4'h5
`define ADDR_LEGACY_BRIDGE_CONFIG 4'h6
`define ADDR_PAGE_PORT_CHOICE 4'h7

// Bit 0 is the msb of the byte, so field bit b sits at data bit 7-b
`define BIT_FORCE_ROOT 7
`define BIT_LONG_RESET 6
`define BIT_LINK_ACTIVE 7
`define BIT_CONTENDER 6
`define BIT_SHORT_RESET 6
`define BIT_ROOT 1
`define BIT_CABLE_POWER 0

`define GAP_RESET 6'h3f
`define EXTENDED_SET 3'h7
`define PORT_COUNT 4'h3
`define LEGACY_SPEED 3'h7
`define REPEATER_LATENCY 4'h2
`define JITTER_VALUE 3'h0
`define PAGE_RESET 3'h0
`define PORT_SEL_RESET 4'h0

// Long bus reset length
`define LONG_RESET_US 166
`define CLOCK_MHZ 200
`define LONG_RESET_CYCLES (`LONG_RESET_US * `CLOCK_MHZ)

`endif

// file: src/phy_base_regs.v
// Base and paged register bank of a three-port serial-bus cable PHY.
// Assumes the link side reaches it over a plain strobe port and that the
// PHY core reports bus resets, tree-ID, self-ID and config packets.
//
// Strobed register access was left to the implementer.
`include "phy_regs_defs.vh"
`default_nettype none

module phy_base_regs #(
	parameter LONG_RESET_CYCLES = `LONG_RESET_CYCLES
) (
	input wire clock_i,
	input wire rstn_i,
	input wire [3:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	input wire bus_reset_i,
	input wire tree_root_i,
	input wire self_id_done_i,
	input wire [5:0] self_id_number_i,
	input wire cfg_gap_valid_i,
	input wire [5:0] cfg_gap_i,
	input wire cfg_force_root_valid_i,
	input wire cfg_force_root_i,
	input wire line_busy_i,
	input wire cable_power_ok_i,
	input wire link_power_status_input_i,
	input wire [2:0] power_class_straps_i,
	input wire [63:0] page0_i,
	input wire [63:0] page1_i,
	input wire [63:0] page7_i,
	output reg [5:0] node_number_o,
	output reg node_number_valid_o,
	output reg [5:0] gap_setting_o,
	output reg force_root_o,
	output reg long_reset_active_o,
	output reg short_reset_pulse_o,
	output reg self_id_link_active_o,
	output reg contender_o,
	output reg [2:0] power_class_o,
	output reg [2:0] page_choice_o,
	output reg [3:0] port_choice_o
);

////////////////////////////////////////////////////////////////////////////
// Counter width; the default long reset count fits in 16 bits
localparam CW = 16;

reg root_r;
reg long_req_r;
reg link_active_r;
reg [6:0] ctl5_r;
reg [7:0] ctl6_r;
reg gap_written_r;
reg prev_reset_r;
reg strap_pending_r;
reg [CW-1:0] reset_cnt_r;
reg [63:0] page_bus;
reg [7:0] page_byte;
reg [7:0] base_byte;
reg [7:0] rd_nxt;
wire wr_gap_reg;
wire wr_power_reg;
wire wr_event_reg;
wire wr_bridge_reg;
wire wr_select_reg;
wire long_start;

////////////////////////////////////////////////////////////////////////////
// Write decode; writes to 0, 2, 3 and 8-F land nowhere
assign wr_gap_reg = wr_i && (addr_i == `ADDR_RESET_GAP_CONTROL);
assign wr_power_reg = wr_i && (addr_i == `ADDR_LINK_POWER_CONFIG);
assign wr_event_reg = wr_i && (addr_i == `ADDR_INTERRUPT_ENABLE_STATUS);
assign wr_bridge_reg = wr_i && (addr_i == `ADDR_LEGACY_BRIDGE_CONFIG);
assign wr_select_reg = wr_i && (addr_i == `ADDR_PAGE_PORT_CHOICE);

// Waits for line traffic and never starts on top of a bus reset
assign long_start = long_req_r && !line_busy_i && !bus_reset_i &&
	!long_reset_active_o;

////////////////////////////////////////////////////////////////////////////
// Node identity: number from self-ID, root flag from tree-ID
always @(posedge clock_i)
begin
	if (!rstn_i)
	begin
		node_number_o <= 6'h00;
		node_number_valid_o <= 1'b0;
		root_r <= 1'b0;
	end
	else
	begin
		if (self_id_done_i)
		begin
			node_number_o <= self_id_number_i;
			node_number_valid_o <= 1'b1;
		end
		if (tree_root_i)
			root_r <= 1'b1;
		// Bus reset wins over the self-ID valid flag and the tree-ID root flag in the same cycle; the node number still loads
		if (bus_reset_i)
		begin
			node_number_valid_o <= 1'b0;
			root_r <= 1'b0;
		end
	end
end

// Force root, long reset request and gap setting
always @(posedge clock_i)
begin
	if (!rstn_i)
	begin
		force_root_o <= 1'b0;
		long_req_r <= 1'b0;
		gap_setting_o <= `GAP_RESET;
		gap_written_r <= 1'b0;
		prev_reset_r <= 1'b0;
	end
	else
	begin
		// The long reset is a bus reset itself, so it drops its request
		if (long_start)
			long_req_r <= 1'b0;
		if (cfg_force_root_valid_i)
			force_root_o <= cfg_force_root_i;
		if (cfg_gap_valid_i)
		begin
			gap_setting_o <= cfg_gap_i;
			gap_written_r <= 1'b1;
		end
		if (wr_gap_reg)
		begin
			force_root_o <= wdata_i[`BIT_FORCE_ROOT];
			long_req_r <= wdata_i[`BIT_LONG_RESET];
			gap_setting_o <= wdata_i[5:0];
			gap_written_r <= 1'b1;
		end
		// Bus reset wins over a long reset request written in the same cycle; a force root write still lands
		if (bus_reset_i)
		begin
			long_req_r <= 1'b0;
			prev_reset_r <= 1'b1;
			gap_written_r <= 1'b0;
			if (prev_reset_r && !gap_written_r)
				gap_setting_o <= `GAP_RESET;
		end
	end
end

// Link control, contender and power class; bus reset leaves them
always @(posedge clock_i)
begin
	if (!rstn_i)
	begin
		link_active_r <= 1'b1;
		contender_o <= 1'b0;
		power_class_o <= 3'h0;
		strap_pending_r <= 1'b1;
	end
	else
	begin
		// Straps caught on the first edge after release, never under reset
		if (strap_pending_r)
		begin
			power_class_o <= power_class_straps_i;
			strap_pending_r <= 1'b0;
		end
		if (wr_power_reg)
		begin
			link_active_r <= wdata_i[`BIT_LINK_ACTIVE];
			contender_o <= wdata_i[`BIT_CONTENDER];
			power_class_o <= wdata_i[2:0];
		end
	end
end

// Event register: enables stored, short reset request is a pulse
always @(posedge clock_i)
begin
	if (!rstn_i)
	begin
		ctl5_r <= 7'h00;
		short_reset_pulse_o <= 1'b0;
	end
	else
	begin
		short_reset_pulse_o <= 1'b0;
		if (wr_event_reg)
		begin
			ctl5_r <= {wdata_i[7], wdata_i[5:0]};
			short_reset_pulse_o <= wdata_i[`BIT_SHORT_RESET];
		end
	end
end

// Bridge register; its two low bits are reserved
always @(posedge clock_i)
begin
	if (!rstn_i)
		ctl6_r <= 8'h00;
	else if (wr_bridge_reg)
		ctl6_r <= {wdata_i[7:2], 2'b00};
end

// Page and port choice
always @(posedge clock_i)
begin
	if (!rstn_i)
	begin
		page_choice_o <= `PAGE_RESET;
		port_choice_o <= `PORT_SEL_RESET;
	end
	else if (wr_select_reg)
	begin
		page_choice_o <= wdata_i[7:5];
		port_choice_o <= wdata_i[3:0];
	end
end

////////////////////////////////////////////////////////////////////////////
// Long bus reset timer; waits for line traffic to finish
always @(posedge clock_i)
begin
	if (!rstn_i)
	begin
		long_reset_active_o <= 1'b0;
		reset_cnt_r <= {CW{1'b0}};
	end
	else if (long_reset_active_o)
	begin
		if (reset_cnt_r == LONG_RESET_CYCLES[CW-1:0] - 1'b1)
			long_reset_active_o <= 1'b0;
		reset_cnt_r <= reset_cnt_r + 1'b1;
	end
	else if (long_start)
	begin
		long_reset_active_o <= 1'b1;
		reset_cnt_r <= {CW{1'b0}};
	end
end

always @(posedge clock_i)
begin
	if (!rstn_i)
		self_id_link_active_o <= 1'b0;
	else
		self_id_link_active_o <= link_active_r &&
			link_power_status_input_i;
end

////////////////////////////////////////////////////////////////////////////
// Page mux; pages 2 to 6 are reserved and read as zero
always @*
begin
	page_bus = 64'h0;
	case (page_choice_o)
	3'h0: page_bus = page0_i;
	3'h1: page_bus = page1_i;
	3'h7: page_bus = page7_i;
	default: page_bus = 64'h0;
	endcase
	page_byte = page_bus[8*addr_i[2:0] +: 8];
end

// Base layout, field bit 0 in data bit 7; same on every page
always @*
begin
	base_byte = 8'h00;
	case (addr_i[2:0])
	3'h0:
		base_byte = {node_number_o, root_r,
			cable_power_ok_i};
	3'h1:
		base_byte = {force_root_o, long_req_r, gap_setting_o};
	3'h2:
		base_byte = {`EXTENDED_SET,
			1'b0, `PORT_COUNT};
	3'h3:
		base_byte = {`LEGACY_SPEED, 1'b0,
			`REPEATER_LATENCY};
	3'h4:
		base_byte = {link_active_r, contender_o, `JITTER_VALUE,
			power_class_o};
	3'h5:
		base_byte = {ctl5_r[6], 1'b0, ctl5_r[5:0]};
	3'h6:
		base_byte = ctl6_r;
	3'h7:
		base_byte = {page_choice_o, 1'b0, port_choice_o};
	default:
		base_byte = 8'h00;
	endcase
end

// Read mux between base and paged halves
always @*
begin
	rd_nxt = 8'h00;
	if (addr_i[3])
		rd_nxt = page_byte;
	else
		rd_nxt = base_byte;
end

// Read data stand one cycle after the strobe, zero otherwise
always @(posedge clock_i)
begin
	if (!rstn_i)
		rdata_o <= 8'h00;
	else if (rd_i)
		rdata_o <= rd_nxt;
	else
		rdata_o <= 8'h00;
end

endmodule // phy_base_regs
`default_nettype wire

// file: testbench/phy_regs_chk.sv
// Checker on the register bank ports.
// Assumes one clock with a synchronous low reset.
`default_nettype none
module phy_regs_chk #(parameter LONG_RESET_CYCLES = 20) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic [3:0] addr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic bus_reset_i,
	input wire logic cfg_force_root_valid_i,
	input wire logic wr_i,
	input wire logic cable_power_ok_i,
	input wire logic force_root_o,
	input wire logic node_number_valid_o,
	input wire logic [5:0] gap_setting_o,
	input wire logic long_reset_active_o,
	input wire logic [2:0] page_choice_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] n_r;
	always_ff @(posedge clock_i)
		if (!rstn_i || !long_reset_active_o)
			n_r <= 16'h0;
		else
			n_r <= n_r + 16'h1;
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!rstn_i);
	ro_ports_a:
	assert property (rd_i && addr_i == 4'h2 |=> rdata_o == 8'he3)
		else $error("port reg");
	ro_speed_a:
	assert property (rd_i && addr_i == 4'h3 |=> rdata_o == 8'he2)
		else $error("speed reg");
	cable_live_a:
	assert property (rd_i && addr_i == 4'h0
		|=> rdata_o[0] == $past(cable_power_ok_i)) else $error("cable");
	page_rsv_a:
	assert property (rd_i && addr_i[3] && page_choice_o inside {[2:6]}
		|=> rdata_o == 8'h0) else $error("reserved page");
	gap_rst_a:
	assert property ($rose(rstn_i) |-> gap_setting_o == 6'h3f)
		else $error("gap reset");
	root_keep_a:
	assert property (bus_reset_i && !wr_i && !cfg_force_root_valid_i
		|=> $stable(force_root_o)) else $error("force root");
	node_inv_a:
	assert property (bus_reset_i |=> !node_number_valid_o)
		else $error("node valid");
	long_len_a:
	assert property ($fell(long_reset_active_o) |-> n_r == LONG_RESET_CYCLES)
		else $error("long reset length");
	cover property (rd_i && addr_i[3]);
	cover property ($fell(long_reset_active_o));
	cover property (bus_reset_i ##[1:40] bus_reset_i);
endmodule // phy_regs_chk
bind phy_base_regs phy_regs_chk #(.LONG_RESET_CYCLES(LONG_RESET_CYCLES))
	phy_regs_chk_i (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .bus_reset_i(bus_reset_i), .wr_i(wr_i),
	.cfg_force_root_valid_i(cfg_force_root_valid_i),
	.cable_power_ok_i(cable_power_ok_i), .force_root_o(force_root_o),
	.node_number_valid_o(node_number_valid_o),
	.gap_setting_o(gap_setting_o), .page_choice_o(page_choice_o),
	.long_reset_active_o(long_reset_active_o));
`default_nettype wire

// file: testbench/link_model.sv
// Link-side master of the register strobe port.
// Assumes read data stand one cycle after the read strobe.
`default_nettype none
module link_model (
	input wire logic clock_i,
	input wire logic [7:0] rdata_i,
	output var logic [3:0] addr_o = 4'h0,
	output var logic [7:0] wdata_o = 8'h0,
	output var logic wr_o = 1'b0,
	output var logic rd_o = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// Force root can go out here too, in bit 7 of a write to register 1, besides by config packet
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clock_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clock_i);
		rd_o <= 1'b0;
		@(posedge clock_i);
		d = rdata_i;
	endtask
endmodule // link_model
`default_nettype wire

// file: testbench/serial_bus_phy_base_regs_tb_top.sv
// Self-checking bench of the register bank.
// Assumes the bank runs alone on one 200 MHz clock.
`default_nettype none
module serial_bus_phy_base_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [4:0] ev = 5'h0;
	logic [5:0] sid = 6'h0;
	logic [5:0] cgap = 6'h0;
	logic cfr = 1'b0, busy = 1'b0, cable_power_ok = 1'b1, link_power_status_input = 1'b1, lra, sla, nv;
	logic [2:0] pcs = 3'h5;
	logic srp;
	logic [63:0] p0 = 64'h0, p1 = 64'h0, p7 = 64'h0;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, d, w, g;
	logic wr, rd;
	integer err_total = 0, tests_run = 0, seed = 94478, i, j;
	always #2.5 clock_i = ~clock_i;
	phy_base_regs #(.LONG_RESET_CYCLES(12)) phy_base_regs_inst (
		.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .bus_reset_i(ev[4]),
		.tree_root_i(ev[3]), .self_id_done_i(ev[2]), .self_id_number_i(sid),
		.cfg_gap_valid_i(ev[1]), .cfg_gap_i(cgap),
		.cfg_force_root_valid_i(ev[0]), .cfg_force_root_i(cfr),
		.line_busy_i(busy), .cable_power_ok_i(cable_power_ok),
		.link_power_status_input_i(link_power_status_input), .power_class_straps_i(pcs),
		.page0_i(p0), .page1_i(p1), .page7_i(p7), .node_number_o(),
		.node_number_valid_o(nv), .gap_setting_o(), .force_root_o(),
		.long_reset_active_o(lra), .short_reset_pulse_o(srp),
		.self_id_link_active_o(sla), .contender_o(), .power_class_o(),
		.page_choice_o(), .port_choice_o());
	link_model link_model_inst (.clock_i(clock_i), .rdata_i(rdata),
		.addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, exp, input string nm);
		tests_run++;
		if (seen !== exp)
		begin
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
			err_total++;
		end
	endtask
	task automatic close_out;
		if (err_total == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] e, string nm);
		link_model_inst.rd(a, d);
		chk(d, e, nm);
	endtask
	task automatic pulse(input logic [4:0] m);
		ev <= m;
		@(posedge clock_i);
		ev <= 5'h0;
	endtask
	// Bounded so a stuck long reset cannot hang the run
	task automatic wait_lr(input logic v);
		for (i = 0; i < 100 && lra !== v; i++)
			@(posedge clock_i);
		chk({7'h0, lra}, {7'h0, v}, "long reset");
		if (lra !== v)
			close_out();
	endtask
	function automatic logic [7:0] pexp(input int p, k);
		return p == 0 ? p0[8*k +: 8] : p == 1 ? p1[8*k +: 8] :
			p == 7 ? p7[8*k +: 8] : 8'h0;
	endfunction
	initial
	begin
		p0 <= {$random(seed), $random(seed)};
		p1 <= {$random(seed), $random(seed)};
		p7 <= {$random(seed), $random(seed)};
		repeat (4) @(posedge clock_i);
		rstn_i <= 1'b1;
		cable_power_ok <= $random(seed);
		link_power_status_input <= $random(seed);
		rchk(4'h1, 8'h3f, "reg1 reset");
		rchk(4'h4, 8'h85, "reg4 reset");
		rchk(4'h0, {7'h0, cable_power_ok}, "reg0 reset");
		link_model_inst.wr(4'h2, 8'h00);
		rchk(4'h2, 8'he3, "reg2 ro");
		sid <= $random(seed);
		pulse(5'h04);
		pulse(5'h08);
		rchk(4'h0, {sid, 1'b1, cable_power_ok}, "node root");
		chk({7'h0, nv}, 8'h01, "node valid");
		g = $random(seed) & 8'h3f;
		link_model_inst.wr(4'h1, g);
		pulse(5'h10);
		link_model_inst.rd(4'h0, d);
		chk(d & 8'h03, {7'h0, cable_power_ok}, "root clear");
		chk({7'h0, nv}, 8'h00, "node invalid");
		rchk(4'h1, g, "gap one reset");
		pulse(5'h10);
		rchk(4'h1, 8'h3f, "gap two resets");
		cgap <= $random(seed);
		cfr <= 1'b1;
		pulse(5'h02);
		pulse(5'h01);
		pulse(5'h10);
		rchk(4'h1, {2'b10, cgap}, "config");
		busy <= 1'b1;
		link_model_inst.wr(4'h1, {2'b11, cgap});
		repeat (6) @(posedge clock_i);
		chk({7'h0, lra}, 8'h0, "busy hold");
		busy <= 1'b0;
		wait_lr(1'b1);
		wait_lr(1'b0);
		link_model_inst.rd(4'h1, d);
		chk(d & 8'hc0, 8'h80, "long req self clear");
		chk({7'h0, lra}, 8'h0, "no restart");
		pulse(5'h10);
		link_model_inst.rd(4'h1, d);
		chk(d & 8'hc0, 8'h80, "long req clear");
		for (i = 0; i < 8; i++)
		begin
			w = $random(seed);
			w[7:4] = {i[2:0], 1'b0};
			link_model_inst.wr(4'h7, w);
			rchk(4'h7, w, "page reg");
			rchk(4'h3, 8'he2, "reg3 paged");
			for (j = 0; j < 8; j++)
				rchk(4'(j + 8), pexp(i, j), "paged");
		end
		w = $random(seed);
		link_model_inst.wr(4'h4, w);
		pulse(5'h10);
		rchk(4'h4, {w[7:6], 3'h0, w[2:0]}, "reg4");
		chk({7'h0, sla}, {7'h0, w[7] & link_power_status_input}, "self-id link");
		w = $random(seed);
		w[6] = 1'b1;
		link_model_inst.wr(4'h5, w);
		@(posedge clock_i);
		chk({7'h0, srp}, 8'h01, "short reset pulse");
		rchk(4'h5, {w[7], 1'b0, w[5:0]}, "reg5");
		chk({7'h0, srp}, 8'h00, "short pulse end");
		link_model_inst.wr(4'h6, w);
		rchk(4'h6, {w[7:2], 2'b00}, "reg6");
		pcs <= $random(seed);
		rstn_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		rstn_i <= 1'b1;
		rchk(4'h1, 8'h3f, "hard reset");
		rchk(4'h4, {5'h10, pcs}, "straps");
		close_out();
	end
endmodule // serial_bus_phy_base_regs_tb_top
`default_nettype wire
